/* File: hdl/swbm_master.sv */
// Single-wire bus master sequencer: reset/presence, write-zero,
// write-one and read slots on an open-drain wire.
// Assumes an external pull-up and inputs synchronous to clk_i.
`timescale 1ns/1ps
`include "swbm_map.svh"
module swbm_master (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command request
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_i,
  output logic cmd_ready_o,
  // Command results
  output logic done_o,
  output logic presence_o,
  output logic rd_bit_o,
  // Open-drain wire
  input wire logic wire_i,
  output logic wire_o,
  output logic wire_oe_n_o
);

  swbm_tick_if tick_if ();

  swbm_tick_gen u_tick (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .tick_if (tick_if)
  );

  // Length of the driven-low part of a slot, in microseconds
  function automatic logic [`SWBM_US_W-1:0] low_len(input swbm_pkg::swbm_cmd_t c);
    unique case (c)
      swbm_pkg::SWBM_CMD_RESET: low_len = `SWBM_RST_LOW_US;
      swbm_pkg::SWBM_CMD_WR0: low_len = `SWBM_W0_LOW_US;
      swbm_pkg::SWBM_CMD_WR1: low_len = `SWBM_W1_LOW_US;
      swbm_pkg::SWBM_CMD_READ: low_len = `SWBM_RD_LOW_US;
    endcase
  endfunction

  // Released part of a slot that follows the low part
  function automatic logic [`SWBM_US_W-1:0] rel_len(input swbm_pkg::swbm_cmd_t c);
    if (c == swbm_pkg::SWBM_CMD_RESET) begin
      rel_len = `SWBM_RST_HIGH_US;
    end else begin
      rel_len = `SWBM_US_W'(`SWBM_SLOT_US - low_len(c));
    end
  endfunction

  swbm_pkg::swbm_state_t state_reg;
  swbm_pkg::swbm_state_t state_next;
  swbm_pkg::swbm_cmd_t cmd_reg;
  swbm_pkg::swbm_cmd_t cmd_next;
  logic [`SWBM_US_W-1:0] us_reg;
  logic [`SWBM_US_W-1:0] us_next;
  logic [`SWBM_US_W-1:0] us_inc;
  logic oe_n_reg;
  logic oe_n_next;
  logic ready_reg;
  logic ready_next;
  logic done_reg;
  logic done_next;
  logic pres_reg;
  logic pres_next;
  logic seen_reg;
  logic seen_next;
  logic rd_reg;
  logic rd_next;
  logic restart;

  assign us_inc = us_reg + `SWBM_US_W'(1);

  // Phase plan of every command:
  // - IDLE: wire released, ready high; a valid command is taken at once.
  // - LOW: wire pulled low for the command's low length in microseconds.
  // - HIGH: wire released for the rest of the slot; a reset uses this
  //   phase to look for the presence pulse, a read samples the wire once.
  // - REC: one more released microsecond, then done and ready together.
  // Each phase restarts us_reg at zero, so every limit is a phase length
  // and no wide counter is needed for the long reset pulse.
  // The tick is realigned when a command is taken, so the first low
  // microsecond is a whole one rather than a fraction of a tick period.
  // Every duration is the nominal one; the pipeline adds about one clock
  // at each phase change, far inside the allowed ranges.
  // Limitation: the wire level is used as it arrives; the pin must be
  // brought into this clock domain before it reaches wire_i.
  // Limitation: a reset pulse and its released time are fixed; a slave
  // that answers late, after the presence window, is reported as absent.
  // Trade-off: the recovery gap is added after every slot, reset too,
  // which costs one microsecond per bit but keeps back-to-back slots
  // legal without any spacing rule for whoever issues commands.
  // Commands offered while busy are ignored; the requester must hold
  // its valid until ready is seen high again.
  // The wire is only ever released or pulled low; wire_o stays zero so
  // an enable fault can never drive the shared line high.

  // Sequencer next-state logic; us_reg counts microseconds within a phase
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    us_next = us_reg;
    oe_n_next = oe_n_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    pres_next = pres_reg;
    seen_next = seen_reg;
    rd_next = rd_reg;
    restart = 1'b0;
    unique case (state_reg)
      swbm_pkg::SWBM_ST_IDLE: begin
        if (cmd_valid_i) begin
          // Falling edge starts the slot and realigns the tick
          cmd_next = swbm_pkg::swbm_cmd_t'(cmd_i);
          state_next = swbm_pkg::SWBM_ST_LOW;
          us_next = '0;
          oe_n_next = 1'b0;
          ready_next = 1'b0;
          seen_next = 1'b0;
          restart = 1'b1;
        end
      end
      swbm_pkg::SWBM_ST_LOW: begin
        if (tick_if.tick) begin
          us_next = us_inc;
          if (us_inc == low_len(cmd_reg)) begin
            // Release only; the pull-up makes the high level
            oe_n_next = 1'b1;
            us_next = '0;
            state_next = swbm_pkg::SWBM_ST_HIGH;
          end
        end
      end
      swbm_pkg::SWBM_ST_HIGH: begin
        // Any low level inside the window counts as presence
        if (cmd_reg == swbm_pkg::SWBM_CMD_RESET && !wire_i &&
            us_reg >= `SWBM_PD_START_US && us_reg < `SWBM_PD_END_US) begin
          seen_next = 1'b1;
        end
        if (tick_if.tick) begin
          us_next = us_inc;
          // Sample point measured from the slot's falling edge
          if (cmd_reg == swbm_pkg::SWBM_CMD_READ &&
              us_inc == `SWBM_US_W'(`SWBM_RD_SAMPLE_US - `SWBM_RD_LOW_US)) begin
            rd_next = wire_i;
          end
          if (us_inc == rel_len(cmd_reg)) begin
            us_next = '0;
            state_next = swbm_pkg::SWBM_ST_REC;
          end
        end
      end
      swbm_pkg::SWBM_ST_REC: begin
        // Extra released gap so back-to-back slots keep their recovery
        if (tick_if.tick) begin
          us_next = us_inc;
          if (us_inc == `SWBM_REC_US) begin
            state_next = swbm_pkg::SWBM_ST_IDLE;
            us_next = '0;
            ready_next = 1'b1;
            done_next = 1'b1;
            if (cmd_reg == swbm_pkg::SWBM_CMD_RESET) begin
              pres_next = seen_reg;
            end
          end
        end
      end
      default: begin
        state_next = swbm_pkg::SWBM_ST_IDLE;
        oe_n_next = 1'b1;
        ready_next = 1'b1;
      end
    endcase
  end

  assign tick_if.restart = restart;

  // Register sequencer state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= swbm_pkg::SWBM_ST_IDLE;
      cmd_reg <= swbm_pkg::SWBM_CMD_RESET;
      us_reg <= '0;
      oe_n_reg <= 1'b1;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      pres_reg <= 1'b0;
      seen_reg <= 1'b0;
      rd_reg <= 1'b0;
      wire_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      us_reg <= us_next;
      oe_n_reg <= oe_n_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      pres_reg <= pres_next;
      seen_reg <= seen_next;
      rd_reg <= rd_next;
      wire_o <= 1'b0; // Never drive high
    end
  end

  assign cmd_ready_o = ready_reg;
  assign done_o = done_reg;
  assign presence_o = pres_reg;
  assign rd_bit_o = rd_reg;
  assign wire_oe_n_o = oe_n_reg;

endmodule

/* File: hdl/swbm_tick_gen.sv */
// Microsecond tick divider for the single-wire bus master.
// Assumes a restart request realigns the tick phase to the slot start.
`timescale 1ns/1ps
`include "swbm_map.svh"
module swbm_tick_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Tick link
  swbm_tick_if.gen tick_if
);

  logic [`SWBM_TICK_W-1:0] cnt_reg;
  logic [`SWBM_TICK_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // Divide the clock down; restart keeps each slot's first microsecond whole
  always_comb begin
    cnt_next = cnt_reg + `SWBM_TICK_W'(1);
    tick_next = 1'b0;
    if (tick_if.restart) begin
      cnt_next = '0;
    end else if (cnt_reg == `SWBM_TICK_W'(`SWBM_TICK_CYCLES - 1)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  // Register divider state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_if.tick = tick_reg;

endmodule

/* File: shared/swbm_map.svh */
// Timing constants for the single-wire bus master sequencer.
// Assumes a 200 MHz clock and a bus with an external pull-up.
`ifndef SWBM_MAP_SVH
`define SWBM_MAP_SVH

`define SWBM_CLK_PERIOD_PS 5000
`define SWBM_TICK_US 1
`define SWBM_TICK_CYCLES ((`SWBM_TICK_US * 1000000) / `SWBM_CLK_PERIOD_PS)
`define SWBM_TICK_W 8
`define SWBM_US_W 10

`define SWBM_RST_LOW_US 10'd511
`define SWBM_RST_HIGH_US 10'd512
`define SWBM_PD_START_US 10'd15
`define SWBM_PD_END_US 10'd300
`define SWBM_W0_LOW_US 10'd100
`define SWBM_W1_LOW_US 10'd5
`define SWBM_RD_LOW_US 10'd5
`define SWBM_SLOT_US 10'd117
`define SWBM_RD_SAMPLE_US 10'd15
`define SWBM_REC_US 10'd1

`endif

/* File: shared/swbm_pkg.sv */
// Types shared by the single-wire bus master sequencer.
// Assumes the timing header is included by the modules that need counts.
package swbm_pkg;

  // Commands accepted on the request port
  typedef enum logic [1:0] {
    SWBM_CMD_RESET = 2'h0,
    SWBM_CMD_WR0 = 2'h1,
    SWBM_CMD_WR1 = 2'h2,
    SWBM_CMD_READ = 2'h3
  } swbm_cmd_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    SWBM_ST_IDLE = 4'h1,
    SWBM_ST_LOW = 4'h2,
    SWBM_ST_HIGH = 4'h4,
    SWBM_ST_REC = 4'h8
  } swbm_state_t;

endpackage

/* File: shared/swbm_tick_if.sv */
// Link between the sequencer and its microsecond tick divider.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface swbm_tick_if;
  logic restart;
  logic tick;

  modport seq (output restart, input tick);
  modport gen (input restart, output tick);
endinterface

/* File: testbench/swbm_master_chk.sv */
// Port checker for the single-wire bus master.
// Assumes 200 clock cycles per microsecond.
`timescale 1ns/1ps
module swbm_master_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic wire_o,
  input wire logic wire_oe_n_o
);
  int lo_reg, lo_next, hi_reg, hi_next, bz_reg, bz_next;
  // Run lengths; released count saturates, so idle after reset reads long
  always_comb begin
    lo_next = wire_oe_n_o ? 0 : lo_reg + 1;
    hi_next = !wire_oe_n_o ? 0 : (hi_reg < 200000) ? hi_reg + 1 : hi_reg;
    bz_next = cmd_ready_o ? 0 : bz_reg + 1;
  end
  // Registers of the run lengths
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_reg <= 0;
      hi_reg <= 200000;
      bz_reg <= 0;
    end else begin
      lo_reg <= lo_next;
      hi_reg <= hi_next;
      bz_reg <= bz_next;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_low_len: assert property (
    $rose(wire_oe_n_o) |-> lo_reg inside {[997:1003], [19997:20003], [102197:102203]})
    else $error("low time off");
  chk_rec_min: assert property (
    $fell(wire_oe_n_o) |-> hi_reg >= 200) else $error("recovery short");
  chk_slot_len: assert property (
    done_o && bz_reg < 30000 |-> bz_reg inside {[23400:24000]}) else $error("slot length");
  chk_reset_high: assert property (
    done_o && bz_reg >= 30000 |-> hi_reg inside {[96000:102800]}) else $error("reset high");
  chk_take_start: assert property (
    cmd_valid_i && cmd_ready_o |=> !cmd_ready_o && !wire_oe_n_o) else $error("no start");
  chk_idle_release: assert property (
    cmd_ready_o |-> wire_oe_n_o) else $error("idle drives");
  chk_done_pulse: assert property (
    done_o |-> cmd_ready_o ##1 !done_o) else $error("done pulse");
  chk_drive_low: assert property (
    wire_o == 1'b0) else $error("wire driven high");
endmodule

/* File: testbench/swbm_slave_model.sv */
// Behavioural slave on the wire: presence pulse and read zeros.
// Assumes 200 clock cycles per microsecond and a pulled-up wire.
`timescale 1ns/1ps
module swbm_slave_model (
  // Clock and wire
  input wire logic clk_i,
  input wire logic line_i,
  // Behaviour controls
  input wire logic zero_i,
  input wire logic [7:0] pd_wait_i,
  input wire logic [7:0] pd_len_i,
  // Pull-down of the wire
  output logic pull_o
);
  int n;
  initial pull_o = 1'b0;
  // Each falling edge from the master opens a slot or a reset
  always @(negedge line_i) begin
    if (!pull_o && zero_i) begin
      @(posedge clk_i);
      pull_o <= 1'b1;
      repeat (6000) @(posedge clk_i); // Held 15 us past the sample point
      pull_o <= 1'b0;
    end else if (!pull_o) begin
      n = 0;
      while (line_i === 1'b0) begin
        @(posedge clk_i);
        n++;
      end
      if (n > 96000) begin
        repeat (pd_wait_i * 200) @(posedge clk_i);
        pull_o <= 1'b1;
        repeat (pd_len_i * 200) @(posedge clk_i);
        pull_o <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the single-wire bus master and a slave model.
// Assumes a 200 MHz clock; a reset command alone takes about 205000 cycles.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_i = 2'h0;
  logic cmd_ready_o, done_o, presence_o, rd_bit_o, wire_o, wire_oe_n_o, pull, line;
  logic zero = 1'b0;
  logic exp_p = 1'b0;
  logic exp_r = 1'b0;
  logic b;
  logic [1:0] note;
  logic [1:0] notes[$];
  logic [7:0] pd_wait = 8'h0F;
  logic [7:0] pd_len = 8'h3C;
  int fails = 0;
  int n_tests = 0;
  integer seed = 32'h575A;
  // Clock and the pulled-up open-drain wire
  always #2.5 clk_i = ~clk_i;
  assign line = (wire_oe_n_o ? 1'b1 : wire_o) & ~pull;
  swbm_master i_swbm_master (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .presence_o(presence_o),
    .rd_bit_o(rd_bit_o), .wire_i(line), .wire_o(wire_o), .wire_oe_n_o(wire_oe_n_o));
  swbm_slave_model i_swbm_slave_model (.clk_i(clk_i), .line_i(line), .zero_i(zero),
    .pd_wait_i(pd_wait), .pd_len_i(pd_len), .pull_o(pull));
  task automatic chk(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Valid stays up between calls, so the next command waits out the busy slot
  task automatic send(input logic [1:0] c, input logic z, input bit keep);
    int k;
    @(negedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    zero <= z;
    if (c == 2'h0) exp_p = 1'b1;
    if (c == 2'h3) exp_r = ~z;
    if (keep) notes.push_back({exp_p, exp_r});
    for (k = 0; k < 250000 && cmd_ready_o !== 1'b1; k++) @(negedge clk_i);
    if (cmd_ready_o !== 1'b1) fails++; // A hang never reaches a pass
    @(posedge clk_i);
  endtask
  // Each done pulse settles the oldest note
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      if (notes.size() == 0) begin
        chk("spare done", 1'b0, 1'b1);
      end else begin
        note = notes.pop_front();
        chk("presence", note[1], presence_o);
        chk("read bit", note[0], rd_bit_o);
      end
    end
  end
  // Main sequence: reset, every slot kind, then a reset in mid-slot
  initial begin
    pd_wait = 8'(15 + {$random(seed)} % 46);
    pd_len = 8'(60 + {$random(seed)} % 181);
    b = 1'($random(seed));
    repeat (10) @(negedge clk_i);
    rst_n_i <= 1'b1;
    send(2'h0, 1'b0, 1'b1);
    send(2'h1, 1'b0, 1'b1);
    send(2'h2, 1'b0, 1'b1);
    send(2'h3, b, 1'b1);
    send(2'h3, ~b, 1'b1);
    send(2'h1, 1'b0, 1'b0);
    repeat (100) @(negedge clk_i);
    rst_n_i <= 1'b0;
    cmd_valid_i <= 1'b0;
    @(negedge clk_i);
    chk("wire released", 1'b1, wire_oe_n_o);
    chk("ready", 1'b1, cmd_ready_o);
    chk("notes left", 1'b1, notes.size() == 0);
    give_verdict();
  end
  // Watchdog: the run needs about 1.5 ms
  initial begin
    #3000000;
    fails++;
    give_verdict();
  end
endmodule
bind swbm_master swbm_master_chk i_swbm_master_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .wire_o(wire_o),
  .wire_oe_n_o(wire_oe_n_o));
